// file: bench/nco_hop_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module nco_hop_core_checker (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic tx_enable_i,
    input wire logic sysref_i,
    input wire logic [nco_hop_pkg::MAIN_W-1:0] phase_o,
    input wire logic carrier_on_o,
    input wire logic [4:0] active_select_o
);
    import nco_hop_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic hop_wr;
    assign hop_wr = reg_wr_i && reg_addr_i == HOP_CTRL_ADDR;

    a_reset_clears: assert property (disable iff (1'b0) rst_i |=>
        phase_o == '0 && !carrier_on_o && active_select_o == 5'h00)
        else $error("outputs not cleared by reset");
    a_carrier_gate: assert property (!carrier_on_o |-> phase_o == '0)
        else $error("phase shown while carrier off");
    a_hop_low_zero: assert property ((active_select_o != 5'h00)[*3] |->
        phase_o[15:0] == 16'h0000)
        else $error("hop phase has low bits set");
    a_select_follow: assert property (hop_wr |=> ##1
        active_select_o == $past(reg_wdata_i[4:0], 2))
        else $error("selection not applied two edges after write");
    a_select_steady: assert property ($changed(active_select_o) |->
        $past(hop_wr, 2))
        else $error("selection changed without a write");
    a_unmapped_zero: assert property (reg_rd_i &&
        reg_addr_i > NUM_TOP_ADDR && reg_addr_i < HOP_CTRL_ADDR |=>
        reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_fields: assert property (reg_rd_i &&
        reg_addr_i == UPDATE_CTRL_ADDR |=>
        !reg_rdata_o[7] && reg_rdata_o[3:2] == 2'b00)
        else $error("reserved control bits read nonzero");
    a_off_quiet: assert property (reg_wr_i &&
        reg_addr_i == DATAPATH_CFG_ADDR && !reg_wdata_i[OSC_EN_BIT] |=> ##1
        (!carrier_on_o && phase_o == '0))
        else $error("oscillator still running after disable");
    a_rdata_stands: assert property (!$past(reg_rd_i) |->
        $stable(reg_rdata_o))
        else $error("read data changed without a read");
endmodule : nco_hop_core_checker
`default_nettype wire

// file: bench/nco_modulus_frequency_hopping_bench.sv
`timescale 1ns/1ps
`default_nettype none
module nco_modulus_frequency_hopping_bench;
    import nco_hop_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [11:0] reg_addr_i = 12'h000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic tx_enable_i = 1'b0;
    logic sysref_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [MAIN_W-1:0] phase_o;
    logic carrier_on_o;
    logic [4:0] active_select_o;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int c0;
    logic [47:0] stored, active, p;
    logic [7:0] d;

    nco_hop_core dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .tx_enable_i(tx_enable_i), .sysref_i(sysref_i), .phase_o(phase_o),
        .carrier_on_o(carrier_on_o), .active_select_o(active_select_o));

    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) cyc <= cyc + 1;

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic note(input string s);
        $display("test %s finished", s);
    endtask : note
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(negedge sys_clk_i);
        reg_addr_i = a;
        reg_wdata_i = v;
        reg_wr_i = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_i = 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        @(negedge sys_clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge sys_clk_i);
        reg_rd_i = 1'b0;
        @(negedge sys_clk_i);
        v = reg_rdata_o;
    endtask : rd
    task automatic wr_word(input logic [11:0] a, input logic [47:0] v,
                           input int n);
        for (int b = 0; b < n; b++) begin
            wr(a + 12'(b), v[8*b +: 8]);
        end
    endtask : wr_word
    // Phase advance over four cycles, after pipeline settles
    task automatic rate(output logic [47:0] s);
        logic [47:0] p0;
        repeat (3) @(negedge sys_clk_i);
        p0 = phase_o;
        repeat (4) @(negedge sys_clk_i);
        s = phase_o - p0;
    endtask : rate
    // Cleared phase shows two edges on; allow a few steps past zero
    task automatic near(input logic [47:0] step);
        logic [47:0] q;
        repeat (2) @(negedge sys_clk_i);
        q = phase_o;
        chk((q % step == 48'h0 && q / step <= 48'd8) ? 48'h0 : q, 48'h0);
    endtask : near

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_i = 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(TUNE_BASE_ADDR + 12'(i), d);
            chk(48'(d), 48'h0);
        end
        rd(HOP_BANK_BASE_ADDR, d);
        chk(48'(d), 48'h0);
        chk(48'(carrier_on_o), 48'h0);
        note("reset");
        wr(DATAPATH_CFG_ADDR, 8'h40);
        stored = 48'h100;
        wr_word(TUNE_BASE_ADDR, stored, 6);
        rate(p);
        chk(p, 48'h0);
        chk(48'(carrier_on_o), 48'h1);
        wr(UPDATE_CTRL_ADDR, 8'h01);
        rd(UPDATE_CTRL_ADDR, d);
        chk(48'(d[1]), 48'h1);
        active = stored;
        rate(p);
        chk(p, active << 2);
        note("manual load");
        for (int t = 1; t <= 6; t++) begin
            wr(UPDATE_CTRL_ADDR, 8'(t << 4));
            stored[8*(t%6) +: 8] = 8'h03;
            wr(TUNE_BASE_ADDR + 12'(t % 6), 8'h03);
            rate(p);
            chk(p, active << 2);
            stored[8*(t-1) +: 8] = 8'h01;
            wr(TUNE_BASE_ADDR + 12'(t - 1), 8'h01);
            active = stored;
            rate(p);
            chk(p, active << 2);
        end
        note("auto update");
        wr_word(DEN_BASE_ADDR, 48'h2, 6);
        wr_word(NUM_BASE_ADDR, 48'h1, 6);
        rd(DEN_BASE_ADDR, d);
        chk(48'(d), 48'h2);
        rd(NUM_BASE_ADDR, d);
        chk(48'(d), 48'h1);
        wr(DATAPATH_CFG_ADDR, 8'h44);
        wr_word(TUNE_BASE_ADDR, 48'h10, 6);
        rate(p);
        chk(p, 48'h42);
        wr(DATAPATH_CFG_ADDR, 8'h40);
        rate(p);
        chk(p, 48'h40);
        note("modulus");
        wr_word(HOP_BANK_BASE_ADDR + 12'h8, 48'h100, 4);
        wr_word(HOP_BANK_BASE_ADDR + 12'hc, 48'h1, 4);
        wr(HOP_CTRL_ADDR, 8'h05);
        repeat (2) @(negedge sys_clk_i);
        chk(phase_o, 48'h0);
        chk(48'(carrier_on_o), 48'h0);
        wr(HOP_CTRL_ADDR, 8'h03);
        rate(p);
        chk(p, 48'h100 << 18);
        chk(48'(active_select_o), 48'h3);
        repeat (30) @(negedge sys_clk_i);
        wr(HOP_CTRL_ADDR, 8'h00);
        repeat (3) @(negedge sys_clk_i);
        chk(phase_o > 48'h1000000 ? 48'h0 : phase_o, 48'h0);
        note("hop select");
        wr(HOP_CTRL_ADDR, 8'h43);
        near(48'h1000000);
        wr(HOP_CTRL_ADDR, 8'h40);
        repeat (50) @(negedge sys_clk_i);
        wr_word(TUNE_BASE_ADDR, 48'h20, 6);
        near(48'h20);
        note("discontinuous");
        wr(HOP_CTRL_ADDR, 8'h80);
        c0 = cyc;
        repeat (40) @(negedge sys_clk_i);
        wr(HOP_CTRL_ADDR, 8'h84);
        rd(HOP_CTRL_ADDR, d);
        chk(48'(d), 48'h84);
        p = phase_o >> 16;
        chk((p + 48'd4 >= 48'(cyc - c0) && p <= 48'(cyc - c0 + 4))
            ? 48'h0 : p, 48'h0);
        chk(48'(active_select_o), 48'h4);
        note("coherent");
        wr(HOP_CTRL_ADDR, 8'h00);
        for (int m = 0; m < 3; m++) begin
            repeat (30) @(negedge sys_clk_i);
            wr(PHASE_RESET_ADDR, 8'(1 << m));
            if (m > 0) begin
                repeat (30) @(negedge sys_clk_i);
                tx_enable_i = (m == 1);
                sysref_i = (m == 2);
                @(negedge sys_clk_i);
                tx_enable_i = 1'b0;
                sysref_i = 1'b0;
            end
            near(48'h20);
        end
        rd(PHASE_RESET_ADDR, d);
        chk(48'(d), 48'h4);
        note("phase reset");
        wr(UPDATE_CTRL_ADDR, 8'h70);
        wr_word(TUNE_BASE_ADDR, 48'h40, 6);
        rate(p);
        chk(p, 48'h80);
        wr(UPDATE_CTRL_ADDR, 8'h00);
        wr(UPDATE_CTRL_ADDR, 8'h01);
        rate(p);
        chk(p, 48'h100);
        note("trigger none");
        wr(12'h300, 8'h5a);
        rd(12'h300, d);
        chk(48'(d), 48'h0);
        wr_word(HOP_BANK_BASE_ADDR + 12'h8, 48'h1, 4);
        wr_word(HOP_BANK_BASE_ADDR + 12'h8, 48'h0, 4);
        wr(HOP_CTRL_ADDR, 8'h03);
        repeat (2) @(negedge sys_clk_i);
        chk(48'(carrier_on_o), 48'h0);
        chk(phase_o, 48'h0);
        wr(HOP_CTRL_ADDR, 8'h00);
        repeat (2) @(negedge sys_clk_i);
        chk(48'(carrier_on_o), 48'h1);
        wr(DATAPATH_CFG_ADDR, 8'h00);
        repeat (2) @(negedge sys_clk_i);
        chk(phase_o, 48'h0);
        chk(48'(carrier_on_o), 48'h0);
        note("power down");
        end_of_test();
    end
endmodule : nco_modulus_frequency_hopping_bench

bind nco_hop_core nco_hop_core_checker checker_i (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .tx_enable_i(tx_enable_i),
    .sysref_i(sysref_i), .phase_o(phase_o), .carrier_on_o(carrier_on_o),
    .active_select_o(active_select_o));
`default_nettype wire

// file: src/nco_hop_core.sv
// Overview of operation
// [R1] Datapath config bit 2 set switches main accumulator to dual-modulus mode.
// [R2] Modulus mode: frequency ratio is (X + A/B) over two to the 48th.
// [R3] X lives at 0x114, A at 0x12A, B at 0x124, six bytes each.
// [R4] Phase reset by register write, transmit-enable pin or SYSREF, within six cycles.
// [R5] Change mode 0b01 clears accumulator on every word update, then counts anew.
// [R6] Automatic mode updates main word when trigger byte written, no load request.
// [R7] Bits 6:4 of 0x113 choose trigger byte; 0b110 is the top byte.
// [R8] Thirty-one extra 32-bit accumulators, each with own preloadable word.
// [R9] Hop select bits 4:0 of 0x800 route one of 32 oscillators out.
// [R10] Change mode: 00 continuous, 01 discontinuous with reset, 10 coherent.
// [R11] Continuous mode keeps accumulator value and carries on at new word.
// [R12] Discontinuous mode clears the accumulator when the new word applies.
// [R13] Entering coherent mode starts all 32 accumulators together; all keep running.
// [R14] Software loads all hop words before selecting coherent mode.
// [R15] Extra oscillator runs only with nonzero word; zero word mutes its output.
// [R16] All tuning words reset to zero.
// [R17] Main accumulator is entry zero; config bit 6 enables it and all accumulators.
// [R18] Software powers an oscillator down by writing 0x0001 then 0x0000.
// [R19] Manual mode: word moves to active on load request rising edge, then acknowledge.
// [R20] Hop select and change mode take effect the cycle after the write.
`timescale 1ns/1ps
`default_nettype none
module nco_hop_core (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic tx_enable_i,
    input wire logic sysref_i,
    output logic [nco_hop_pkg::MAIN_W-1:0] phase_o,
    output logic carrier_on_o,
    output logic [4:0] active_select_o
);
    import nco_hop_pkg::*;

    logic [7:0] dp_cfg_reg;
    logic load_req_reg;
    logic load_ack_reg;
    logic [2:0] trig_sel_reg;
    logic [7:0] tune_byte_reg [0:TUNE_BYTES-1];
    logic [7:0] den_byte_reg [0:TUNE_BYTES-1];
    logic [7:0] num_byte_reg [0:TUNE_BYTES-1];
    logic [MAIN_W-1:0] tune_active_reg;
    logic [4:0] hop_sel_reg;
    change_mode_t mode_reg;
    change_mode_t mode_prev_reg;
    logic [1:0] rst_src_reg;
    logic tx_en_prev_reg;
    logic sysref_prev_reg;
    logic [MAIN_W-1:0] word_prev_reg;
    logic [MAIN_W-1:0] main_acc_reg;
    logic [MAIN_W-1:0] frac_acc_reg;
    logic [HOP_W-1:0] hop_word_reg [1:HOP_N-1];
    logic [HOP_W-1:0] hop_acc_reg [1:HOP_N-1];

    // Address decode
    logic wr_cfg, wr_upd, wr_tune, wr_den, wr_num;
    logic wr_hop_ctrl, wr_rst, wr_bank;
    logic in_tune, in_den, in_num, in_bank;
    logic [11:0] tune_off, den_off, num_off, bank_off;
    logic [2:0] tune_idx, den_idx, num_idx;
    logic [4:0] bank_entry;
    logic [1:0] bank_byte;

    always_comb begin
        in_tune = 1'b0;
        in_den = 1'b0;
        in_num = 1'b0;
        in_bank = 1'b0;
        if (reg_addr_i >= TUNE_BASE_ADDR && reg_addr_i <= TUNE_TOP_ADDR) begin
            in_tune = 1'b1;
        end else if (reg_addr_i >= DEN_BASE_ADDR
                     && reg_addr_i <= DEN_TOP_ADDR) begin
            in_den = 1'b1;
        end else if (reg_addr_i >= NUM_BASE_ADDR
                     && reg_addr_i <= NUM_TOP_ADDR) begin
            in_num = 1'b1;
        end else if (reg_addr_i >= HOP_BANK_BASE_ADDR
                     && reg_addr_i <= HOP_BANK_TOP_ADDR) begin
            in_bank = 1'b1;
        end
    end

    assign tune_off = reg_addr_i - TUNE_BASE_ADDR;
    assign den_off = reg_addr_i - DEN_BASE_ADDR;
    assign num_off = reg_addr_i - NUM_BASE_ADDR;
    assign bank_off = reg_addr_i - HOP_BANK_BASE_ADDR;
    assign tune_idx = tune_off[2:0];
    assign den_idx = den_off[2:0];
    assign num_idx = num_off[2:0];
    assign bank_entry = bank_off[6:2] + 5'd1;
    assign bank_byte = bank_off[1:0];

    assign wr_cfg = reg_wr_i && reg_addr_i == DATAPATH_CFG_ADDR;
    assign wr_upd = reg_wr_i && reg_addr_i == UPDATE_CTRL_ADDR;
    assign wr_tune = reg_wr_i && in_tune;
    assign wr_den = reg_wr_i && in_den;
    assign wr_num = reg_wr_i && in_num;
    assign wr_hop_ctrl = reg_wr_i && reg_addr_i == HOP_CTRL_ADDR;
    assign wr_rst = reg_wr_i && reg_addr_i == PHASE_RESET_ADDR;
    assign wr_bank = reg_wr_i && in_bank;

    // Configuration fields
    logic mod_en, osc_en;
    logic [MAIN_W-1:0] den_word, num_word, tune_shadow_next;
    assign mod_en = dp_cfg_reg[MOD_EN_BIT]; // [R1]
    assign osc_en = dp_cfg_reg[OSC_EN_BIT]; // [R17]

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            dp_cfg_reg <= DATAPATH_CFG_RESET;
        end else if (wr_cfg) begin
            dp_cfg_reg <= reg_wdata_i;
        end
    end

    // Tuning, numerator and denominator byte storage
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < TUNE_BYTES; i++) begin
                tune_byte_reg[i] <= BYTE_RESET; // [R16]
                den_byte_reg[i] <= BYTE_RESET;
                num_byte_reg[i] <= BYTE_RESET;
            end
        end else begin
            if (wr_tune) begin
                tune_byte_reg[tune_idx] <= reg_wdata_i; // [R3]
            end
            if (wr_den) begin
                den_byte_reg[den_idx] <= reg_wdata_i; // [R3]
            end
            if (wr_num) begin
                num_byte_reg[num_idx] <= reg_wdata_i; // [R3]
            end
        end
    end

    always_comb begin
        for (int i = 0; i < TUNE_BYTES; i++) begin
            den_word[i*8 +: 8] = den_byte_reg[i];
            num_word[i*8 +: 8] = num_byte_reg[i];
            tune_shadow_next[i*8 +: 8] = tune_byte_reg[i];
        end
        // Merge the byte being written so an auto update sees it at once
        if (wr_tune) begin
            tune_shadow_next[tune_idx*8 +: 8] = reg_wdata_i;
        end
    end

    // Main word update: load request edge or automatic trigger byte
    logic manual_mode, req_rise, auto_hit, main_load;
    assign manual_mode = trig_sel_reg == TRIG_MANUAL;
    assign req_rise = wr_upd && reg_wdata_i[LOAD_REQ_BIT] && !load_req_reg;
    assign auto_hit = wr_tune && !manual_mode
                      && tune_idx == trig_sel_reg - 3'd1; // [R6] [R7]
    assign main_load = (manual_mode && req_rise) || auto_hit; // [R19]

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            load_req_reg <= 1'b0;
            trig_sel_reg <= TRIG_SEL_RESET;
        end else if (wr_upd) begin
            load_req_reg <= reg_wdata_i[LOAD_REQ_BIT];
            trig_sel_reg <= reg_wdata_i[TRIG_SEL_LSB +: 3]; // [R7]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tune_active_reg <= '0; // [R16]
        end else if (main_load) begin
            tune_active_reg <= tune_shadow_next; // [R6] [R19]
        end
    end

    // Acknowledge: set wins over the clear from writing request low
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            load_ack_reg <= 1'b0;
        end else if (main_load && manual_mode) begin
            load_ack_reg <= 1'b1; // [R19]
        end else if (wr_upd && !reg_wdata_i[LOAD_REQ_BIT]) begin
            load_ack_reg <= 1'b0;
        end
    end

    // Hop control, applied from the next cycle as a whole byte
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            hop_sel_reg <= HOP_SEL_RESET;
            mode_reg <= CHG_CONTINUOUS;
        end else if (wr_hop_ctrl) begin
            hop_sel_reg <= reg_wdata_i[HOP_SEL_LSB +: 5]; // [R9] [R20]
            mode_reg <= change_mode_t'(reg_wdata_i[CHG_MODE_LSB +: 2]); // [R20]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode_prev_reg <= CHG_CONTINUOUS;
        end else begin
            mode_prev_reg <= mode_reg;
        end
    end

    // Phase reset sources; the write strobe is not stored
    logic tx_rise, sysref_rise, phase_reset_evt;
    assign tx_rise = tx_enable_i && !tx_en_prev_reg;
    assign sysref_rise = sysref_i && !sysref_prev_reg;
    assign phase_reset_evt = (wr_rst && reg_wdata_i[RST_SPI_BIT])
                             || (rst_src_reg[0] && tx_rise)
                             || (rst_src_reg[1] && sysref_rise); // [R4]

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rst_src_reg <= 2'b00;
        end else if (wr_rst) begin
            rst_src_reg <= {reg_wdata_i[RST_SYSREF_BIT],
                            reg_wdata_i[RST_TXEN_BIT]};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_en_prev_reg <= 1'b0;
            sysref_prev_reg <= 1'b0;
        end else begin
            tx_en_prev_reg <= tx_enable_i;
            sysref_prev_reg <= sysref_i;
        end
    end

    // Selected word; entry zero is the main 48-bit word
    logic [MAIN_W-1:0] sel_word;
    logic coherent, coherent_entry, word_change, clear_all, sel_live;
    always_comb begin
        if (hop_sel_reg == 5'd0) begin
            sel_word = tune_active_reg; // [R17]
            sel_live = 1'b1;
        end else begin
            sel_word = {hop_word_reg[hop_sel_reg], 16'h0000};
            sel_live = hop_word_reg[hop_sel_reg] != '0; // [R15]
        end
    end

    assign coherent = mode_reg == CHG_COHERENT;
    assign coherent_entry = coherent && mode_prev_reg != CHG_COHERENT; // [R13]
    assign word_change = sel_word != word_prev_reg;
    // Disabled oscillator holds every accumulator at zero
    assign clear_all = !osc_en || phase_reset_evt || coherent_entry; // [R17]

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            word_prev_reg <= '0;
        end else begin
            word_prev_reg <= sel_word;
        end
    end

    // Dual-modulus fraction: carry one extra LSB each time A/B wraps
    logic [MAIN_W:0] frac_sum;
    logic frac_carry;
    logic [MAIN_W-1:0] frac_next, main_step, main_sum;
    always_comb begin
        frac_sum = {1'b0, frac_acc_reg} + {1'b0, num_word};
        frac_carry = 1'b0;
        frac_next = frac_sum[MAIN_W-1:0];
        // B of zero would wrap on every cycle, so the fraction is ignored
        if (mod_en && den_word != '0 && frac_sum >= {1'b0, den_word}) begin
            frac_carry = 1'b1; // [R2]
            frac_next = frac_sum[MAIN_W-1:0] - den_word;
        end
        main_step = coherent ? tune_active_reg : sel_word; // [R11]
        main_sum = main_acc_reg + main_step + MAIN_W'(frac_carry); // [R2]
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || clear_all) begin
            main_acc_reg <= '0;
            frac_acc_reg <= '0;
        end else if (!coherent && mode_reg == CHG_DISCONTINUOUS
                     && word_change) begin
            main_acc_reg <= '0; // [R5] [R10] [R12]
            frac_acc_reg <= '0;
        end else begin
            main_acc_reg <= main_sum; // [R11]
            frac_acc_reg <= mod_en ? frac_next : '0;
        end
    end

    // Hopping bank: one word and one accumulator per extra entry
    genvar k;
    generate
        for (k = 1; k < HOP_N; k++) begin : g_hop
            always_ff @(posedge sys_clk_i) begin
                if (rst_i) begin
                    hop_word_reg[k] <= '0; // [R16]
                end else if (wr_bank && bank_entry == 5'(k)) begin
                    hop_word_reg[k][bank_byte*8 +: 8] <= reg_wdata_i; // [R8]
                end
            end

            // Zero word freezes the accumulator rather than clearing it
            always_ff @(posedge sys_clk_i) begin
                if (rst_i || clear_all) begin
                    hop_acc_reg[k] <= '0; // [R13] [R17]
                end else if (coherent && hop_word_reg[k] != '0) begin
                    hop_acc_reg[k] <= hop_acc_reg[k] + hop_word_reg[k]; // [R15]
                end
            end
        end
    endgenerate

    // Output stage
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            phase_o <= '0;
            carrier_on_o <= 1'b0;
            active_select_o <= HOP_SEL_RESET;
        end else begin
            active_select_o <= hop_sel_reg; // [R9]
            carrier_on_o <= osc_en && sel_live; // [R15] [R17]
            if (!(osc_en && sel_live)) begin
                phase_o <= '0;
            end else if (coherent && hop_sel_reg != 5'd0) begin
                phase_o <= {hop_acc_reg[hop_sel_reg], 16'h0000}; // [R13]
            end else if (hop_sel_reg != 5'd0) begin
                // Hop entries are 32 bits wide; hide main low bits
                // Leftover low bits would otherwise show after a hop
                phase_o <= {main_acc_reg[MAIN_W-1:16], 16'h0000}; // [R8]
            end else begin
                phase_o <= main_acc_reg;
            end
        end
    end

    // Register readback, one cycle after the read strobe
    logic [7:0] rdata_next;
    always_comb begin
        rdata_next = 8'h00;
        if (reg_addr_i == DATAPATH_CFG_ADDR) begin
            rdata_next = dp_cfg_reg;
        end else if (reg_addr_i == UPDATE_CTRL_ADDR) begin
            rdata_next = {1'b0, trig_sel_reg, 2'b00,
                          load_ack_reg, load_req_reg};
        end else if (in_tune) begin
            rdata_next = tune_byte_reg[tune_idx];
        end else if (in_den) begin
            rdata_next = den_byte_reg[den_idx];
        end else if (in_num) begin
            rdata_next = num_byte_reg[num_idx];
        end else if (reg_addr_i == HOP_CTRL_ADDR) begin
            rdata_next = {mode_reg, 1'b0, hop_sel_reg};
        end else if (reg_addr_i == PHASE_RESET_ADDR) begin
            rdata_next = {5'b00000, rst_src_reg, 1'b0};
        end else if (in_bank) begin
            rdata_next = hop_word_reg[bank_entry][bank_byte*8 +: 8];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_next;
        end
    end
endmodule : nco_hop_core
`default_nettype wire

// file: src/nco_hop_pkg.sv
package nco_hop_pkg;
    // Register byte addresses on the serial-port register map
    localparam logic [11:0] DATAPATH_CFG_ADDR = 12'h111;
    localparam logic [11:0] UPDATE_CTRL_ADDR = 12'h113;
    localparam logic [11:0] TUNE_BASE_ADDR = 12'h114;
    localparam logic [11:0] TUNE_TOP_ADDR = 12'h119;
    localparam logic [11:0] DEN_BASE_ADDR = 12'h124;
    localparam logic [11:0] DEN_TOP_ADDR = 12'h129;
    localparam logic [11:0] NUM_BASE_ADDR = 12'h12a;
    localparam logic [11:0] NUM_TOP_ADDR = 12'h12f;
    localparam logic [11:0] HOP_CTRL_ADDR = 12'h800;
    localparam logic [11:0] PHASE_RESET_ADDR = 12'h801;
    localparam logic [11:0] HOP_BANK_BASE_ADDR = 12'h804;
    localparam logic [11:0] HOP_BANK_TOP_ADDR = 12'h87f;

    // Field positions
    localparam int MOD_EN_BIT = 2;
    localparam int OSC_EN_BIT = 6;
    localparam int LOAD_REQ_BIT = 0;
    localparam int LOAD_ACK_BIT = 1;
    localparam int TRIG_SEL_LSB = 4;
    localparam int HOP_SEL_LSB = 0;
    localparam int CHG_MODE_LSB = 6;
    localparam int RST_SPI_BIT = 0;
    localparam int RST_TXEN_BIT = 1;
    localparam int RST_SYSREF_BIT = 2;

    // Reset values
    localparam logic [7:0] DATAPATH_CFG_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [4:0] HOP_SEL_RESET = 5'h00;
    localparam logic [2:0] TRIG_SEL_RESET = 3'h0;

    // Sizes
    localparam int MAIN_W = 48;
    localparam int HOP_W = 32;
    localparam int HOP_N = 32;
    localparam int TUNE_BYTES = 6;

    // Trigger select value meaning load-request driven update
    localparam logic [2:0] TRIG_MANUAL = 3'h0;

    typedef enum logic [1:0] {
        CHG_CONTINUOUS = 2'b00,
        CHG_DISCONTINUOUS = 2'b01,
        CHG_COHERENT = 2'b10,
        CHG_UNUSED = 2'b11
    } change_mode_t;
endpackage : nco_hop_pkg
